// [hw/cdb_params.svh]
`ifndef CDB_PARAMS_SVH
`define CDB_PARAMS_SVH

// ---------------------------------------------------------------------
// Address map
// ---------------------------------------------------------------------
`define CDB_UPDCTL_ADDR   16'h0090
`define CDB_ERASE_ADDR    16'h0091
`define CDB_RELOAD_ADDR   16'h00d8
`define CDB_NVM_BASE      16'hf800
`define CDB_UPDCTL_RST    8'h00

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define CDB_TRANSP_BIT    0
`define CDB_COMMIT_BIT    1
`define CDB_ERASE_EN_BIT  2
`define CDB_RELOAD_BIT    0

// ---------------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------------
`define CDB_PAGE_BYTES    32
`define CDB_CFG_PAGES     7
`define CDB_NVM_PAGES     16
`define CDB_ERASED        8'hff
`define CDB_CLK_PERIOD_NS 50
`define CDB_LOCKOUT_MV    2500
`define CDB_SE_DELAY_NS   500000

`endif

// [hw/cdb_pkg.sv]
package cdb_pkg;

   typedef enum logic [2:0] {
      ST_LOCKOUT,
      ST_COPY,
      ST_XFER,
      ST_SE_WAIT,
      ST_SE_LOAD,
      ST_RUN
   } cdb_state_e;

   typedef logic [7:0]  cdb_byte_t;
   typedef logic [15:0] cdb_addr_t;

endpackage

// [hw/cdb_lat_if.sv]
`timescale 1ns/10ps
interface cdb_lat_if #(parameter int N = 224);
   logic                  wr_en;
   logic [$clog2(N)-1:0]  wr_idx;
   logic [7:0]            wr_data;
   logic                  transparent;
   logic                  load_b;
   logic [N-1:0][7:0]     a_q;
   logic [N-1:0][7:0]     b_q;

   modport ctrl (output wr_en, wr_idx, wr_data, transparent, load_b, input a_q, b_q);
   modport bank (input wr_en, wr_idx, wr_data, transparent, load_b, output a_q, b_q);
endinterface

// [hw/cdb_latch_bank.sv]
`timescale 1ns/10ps
module cdb_latch_bank
(
   input wire logic MCLK,
   input wire logic RST_N,
   cdb_lat_if.bank  lat
);
   // -------------------------------------------------------------------
   // First stage
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         lat.a_q <= '0;
      else if (lat.wr_en)
         lat.a_q[lat.wr_idx] <= lat.wr_data;
   end

   // -------------------------------------------------------------------
   // Second stage
   // -------------------------------------------------------------------
   // A load pulse copies the whole first stage at once. In transparent
   // mode a write also lands here directly.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         lat.b_q <= '0;
      else if (lat.load_b)
         lat.b_q <= lat.a_q;
      else if (lat.transparent && lat.wr_en)
         lat.b_q[lat.wr_idx] <= lat.wr_data;
   end
endmodule // cdb_latch_bank

// [hw/cdb_top.sv]
// Functional notes
// - Download starts only once supply is above the 2.5 V lockout level.
// - Download fills every first-stage latch before any second stage changes.
// - All second stages then load together, completing the download.
// - First sequencing state is fetched 0.5 ms after the power-up download completes, not after a user download.
// - Bus requests get no acknowledge until the download is complete.
// - Control bit 0 set: both latch stages transparent, writes act at once.
// - Control bit 0 clear: writes reach first stage only until commit.
// - Writing 1 to control bit 1 pulses a load of all second stages.
// - Nonvolatile writes follow the same staged commit behaviour, but only the last staged byte is kept for the commit.
// - With erase enabled, page erase sets every page byte to all ones.
// - With erase disabled, page erase is ignored and the page kept.
// - Nonvolatile contents change without touching the volatile latches.
// - A download command overwrites volatile registers from nonvolatile store.
// - Bit 0 of the reload register starts a user download when the sequencer is in ST_RUN.
// - Download covers pages 0 to 6 from the nonvolatile base address.
`timescale 1ns/10ps
`include "cdb_params.svh"
module cdb_top
#(
   parameter int CFG_BYTES    = `CDB_CFG_PAGES * `CDB_PAGE_BYTES,
   parameter int NVM_BYTES    = `CDB_NVM_PAGES * `CDB_PAGE_BYTES,
   parameter int SE_DELAY_CYC =
      (`CDB_SE_DELAY_NS + `CDB_CLK_PERIOD_NS - 1) / `CDB_CLK_PERIOD_NS
)
(
   input  wire logic                  MCLK,
   input  wire logic                  RST_N,
   input  wire logic                  SUPPLY_OK,
   input  wire logic                  REQ_VALID,
   input  wire logic                  REQ_WRITE,
   input  wire cdb_pkg::cdb_addr_t    REQ_ADDR,
   input  wire cdb_pkg::cdb_byte_t    REQ_WDATA,
   output logic                       REQ_ACK,
   output cdb_pkg::cdb_byte_t         RDATA,
   output logic                       DL_BUSY,
   output logic                       SE_FETCH,
   output logic [CFG_BYTES*8-1:0]     ACTIVE_CFG
);
   import cdb_pkg::*;

   localparam int IW = $clog2(CFG_BYTES);
   localparam int NW = $clog2(NVM_BYTES);
   localparam int PW = $clog2(`CDB_NVM_PAGES);
   localparam int CW = $clog2(SE_DELAY_CYC + 1);

   cdb_lat_if #(.N(CFG_BYTES)) lat ();

   cdb_state_e           state_r;
   logic [IW-1:0]        idx_r;
   logic [CW-1:0]        se_cnt_r;
   logic                 powerup_r;
   cdb_byte_t            ctrl_r;
   logic                 commit_r;
   logic                 pend_v_r;
   logic [NW-1:0]        pend_idx_r;
   cdb_byte_t            pend_data_r;
   logic [NVM_BYTES-1:0][7:0] nvm_r;
   cdb_byte_t            rdata_r;

   logic                 acc;
   logic                 wr;
   logic                 in_cfg;
   logic                 in_nvm;
   logic [15:0]          nvm_off;
   logic                 nvm_we;
   logic [NW-1:0]        nvm_widx;
   cdb_byte_t            nvm_wdata;
   logic                 erase_go;
   logic                 commit_wr;
   logic                 reload_wr;
   logic                 transp;

   // -------------------------------------------------------------------
   // Request decode
   // -------------------------------------------------------------------
   assign DL_BUSY   = (state_r == ST_LOCKOUT) || (state_r == ST_COPY)
                      || (state_r == ST_XFER);
   assign REQ_ACK   = REQ_VALID && !DL_BUSY;
   assign acc       = REQ_ACK;
   assign wr        = acc && REQ_WRITE;
   assign transp    = ctrl_r[`CDB_TRANSP_BIT];
   assign in_cfg    = (REQ_ADDR < 16'(CFG_BYTES)) && (REQ_ADDR != `CDB_UPDCTL_ADDR)
                      && (REQ_ADDR != `CDB_ERASE_ADDR) && (REQ_ADDR != `CDB_RELOAD_ADDR);
   assign nvm_off   = REQ_ADDR - `CDB_NVM_BASE;
   assign in_nvm    = (REQ_ADDR >= `CDB_NVM_BASE) && (nvm_off < 16'(NVM_BYTES));
   assign commit_wr = wr && (REQ_ADDR == `CDB_UPDCTL_ADDR)
                      && REQ_WDATA[`CDB_COMMIT_BIT];
   assign reload_wr = wr && (REQ_ADDR == `CDB_RELOAD_ADDR)
                      && REQ_WDATA[`CDB_RELOAD_BIT];
   assign erase_go  = wr && (REQ_ADDR == `CDB_ERASE_ADDR)
                      && ctrl_r[`CDB_ERASE_EN_BIT];
   assign SE_FETCH  = (state_r == ST_SE_LOAD);
   assign ACTIVE_CFG = lat.b_q;
   assign RDATA     = rdata_r;

   // -------------------------------------------------------------------
   // Download sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_r   <= ST_LOCKOUT;
         idx_r     <= '0;
         powerup_r <= 1'b1;
      end
      else
      begin
         unique case (state_r)
            ST_LOCKOUT:
               if (SUPPLY_OK)
                  state_r <= ST_COPY;
            ST_COPY:
               if (idx_r == IW'(CFG_BYTES - 1))
                  state_r <= ST_XFER;
               else
                  idx_r <= idx_r + 1'b1;
            ST_XFER:
            begin
               idx_r     <= '0;
               powerup_r <= 1'b0;
               state_r   <= powerup_r ? ST_SE_WAIT : ST_RUN;
            end
            ST_SE_WAIT:
               if (se_cnt_r == CW'(SE_DELAY_CYC - 1))
                  state_r <= ST_SE_LOAD;
            ST_SE_LOAD:
               state_r <= ST_RUN;
            ST_RUN:
               if (reload_wr)
                  state_r <= ST_COPY;
         endcase
      end
   end

   // The start timer only runs once the busy flag has dropped.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         se_cnt_r <= '0;
      else if (state_r == ST_SE_WAIT && !DL_BUSY)
         se_cnt_r <= se_cnt_r + 1'b1;
      else
         se_cnt_r <= '0;
   end

   // -------------------------------------------------------------------
   // Update control register
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         ctrl_r <= `CDB_UPDCTL_RST;
      else if (wr && REQ_ADDR == `CDB_UPDCTL_ADDR)
      begin
         ctrl_r <= REQ_WDATA;
         ctrl_r[`CDB_COMMIT_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         commit_r <= 1'b0;
      else
         commit_r <= commit_wr;
   end

   // -------------------------------------------------------------------
   // Latch bank control
   // -------------------------------------------------------------------
   always_comb
   begin
      lat.transparent = transp && (state_r != ST_COPY);
      lat.load_b      = commit_r || (state_r == ST_XFER);
      if (state_r == ST_COPY)
      begin
         lat.wr_en   = 1'b1;
         lat.wr_idx  = idx_r;
         lat.wr_data = nvm_r[idx_r];
      end
      else
      begin
         lat.wr_en   = wr && in_cfg;
         lat.wr_idx  = REQ_ADDR[IW-1:0];
         lat.wr_data = REQ_WDATA;
      end
   end

   cdb_latch_bank u_bank
   (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .lat   (lat)
   );

   // -------------------------------------------------------------------
   // Nonvolatile store
   // -------------------------------------------------------------------
   // Staged writes hold one pending byte; a second staged write before
   // the commit replaces it, which keeps the store simple.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pend_v_r    <= 1'b0;
         pend_idx_r  <= '0;
         pend_data_r <= '0;
      end
      else if (wr && in_nvm && !transp)
      begin
         pend_v_r    <= 1'b1;
         pend_idx_r  <= nvm_off[NW-1:0];
         pend_data_r <= REQ_WDATA;
      end
      else if (commit_r)
         pend_v_r <= 1'b0;
   end

   assign nvm_we    = (wr && in_nvm && transp) || (commit_r && pend_v_r);
   assign nvm_widx  = (commit_r && pend_v_r) ? pend_idx_r : nvm_off[NW-1:0];
   assign nvm_wdata = (commit_r && pend_v_r) ? pend_data_r : REQ_WDATA;

   for (genvar g = 0; g < NVM_BYTES; g++)
   begin : g_nvm
      always_ff @(posedge MCLK or negedge RST_N)
      begin
         if (!RST_N)
            nvm_r[g] <= `CDB_ERASED;
         else if (erase_go && REQ_WDATA[PW-1:0] == PW'(g / `CDB_PAGE_BYTES))
            nvm_r[g] <= `CDB_ERASED;
         else if (nvm_we && nvm_widx == NW'(g))
            nvm_r[g] <= nvm_wdata;
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         rdata_r <= '0;
      else if (acc && !REQ_WRITE)
      begin
         if (in_cfg)
            rdata_r <= lat.a_q[REQ_ADDR[IW-1:0]];
         else if (in_nvm)
            rdata_r <= nvm_r[nvm_off[NW-1:0]];
         else if (REQ_ADDR == `CDB_UPDCTL_ADDR)
            rdata_r <= ctrl_r;
         else
            rdata_r <= '0;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   logic [CW:0] since_dl_r;
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         since_dl_r <= '0;
      else if (state_r == ST_XFER)
         since_dl_r <= '0;
      else if (!(&since_dl_r))
         since_dl_r <= since_dl_r + 1'b1;
   end

   a_lockout_hold: assert property ((state_r == ST_LOCKOUT && !SUPPLY_OK)
      |=> state_r == ST_LOCKOUT) else $error("download left lockout early");
   a_copy_no_b: assert property ((state_r == ST_COPY && !commit_r) |-> !lat.load_b)
      else $error("second stage loaded during copy");
   a_xfer_done: assert property (state_r == ST_XFER |-> lat.load_b ##1 !DL_BUSY)
      else $error("transfer did not end download");
   a_se_delay: assert property (SE_FETCH |-> since_dl_r == (CW+1)'(SE_DELAY_CYC))
      else $error("sequencer fetch at wrong time");
   a_busy_nack: assert property (DL_BUSY |-> !REQ_ACK)
      else $error("ack while download busy");
   a_staged_hold: assert property ((!lat.load_b && !(lat.transparent && lat.wr_en))
      |=> $stable(lat.b_q)) else $error("active config changed unstaged");
   a_transp_write: assert property ((transp && wr && in_cfg && !lat.load_b)
      |=> lat.b_q[$past(REQ_ADDR[IW-1:0])] == $past(REQ_WDATA))
      else $error("transparent write not applied");
   a_commit_pulse: assert property (commit_wr |=> lat.load_b ##1 !commit_r
      && !ctrl_r[`CDB_COMMIT_BIT]) else $error("commit pulse wrong");
   a_erase_ones: assert property (erase_go
      |=> nvm_r[NW'($past(REQ_WDATA[PW-1:0]) * `CDB_PAGE_BYTES)] == `CDB_ERASED)
      else $error("page not erased");
   a_erase_off: assert property ((wr && REQ_ADDR == `CDB_ERASE_ADDR
      && !ctrl_r[`CDB_ERASE_EN_BIT] && !nvm_we) |=> $stable(nvm_r))
      else $error("erase acted while disabled");
   a_reload_start: assert property (reload_wr |=> state_r == ST_COPY && DL_BUSY)
      else $error("reload did not start");

   c_powerup: cover property (state_r == ST_XFER ##1 state_r == ST_SE_WAIT);
   c_commit: cover property (commit_wr ##1 lat.load_b);
   c_erase: cover property (erase_go);
   c_reload: cover property (reload_wr ##[1:300] state_r == ST_RUN);
endmodule // cdb_top

// [verification/cdb_host_model.sv]
`timescale 1ns/10ps
module cdb_host_model
(
   input  wire logic               mclk,
   output logic                    req_valid,
   output logic                    req_write,
   output cdb_pkg::cdb_addr_t      req_addr,
   output cdb_pkg::cdb_byte_t      req_wdata,
   input  wire logic               req_ack,
   input  wire cdb_pkg::cdb_byte_t rdata
);
   import cdb_pkg::*;

   initial
   begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = 16'h0000;
      req_wdata = 8'h00;
   end

   // ------------------------------------------------------------
   // One request, held until taken or the wait limit runs out
   // ------------------------------------------------------------
   // Released address and data are inverted so a stale value never looks valid.
   task automatic xfer(input logic w, input cdb_addr_t a, input cdb_byte_t d,
                       input int limit, output cdb_byte_t rd, output logic ok);
      int n;
      n  = 0;
      ok = 1'b0;
      @(posedge mclk);
      #2;
      req_valid = 1'b1;
      req_write = w;
      req_addr  = a;
      req_wdata = d;
      while (!ok && n < limit)
      begin
         @(negedge mclk);
         if (req_ack === 1'b1)
            ok = 1'b1;
         else
            n++;
      end
      @(posedge mclk);
      #2;
      req_valid = 1'b0;
      req_addr  = ~a;
      req_wdata = ~d;
      rd        = rdata;
   endtask
endmodule // cdb_host_model

// [verification/config_download_double_buffer_tb.sv]
`timescale 1ns/10ps
module config_download_double_buffer_tb;
   import cdb_pkg::*;
   localparam int CB = 8;
   localparam int SD = 8;

   logic             MCLK = 1'b0;
   logic             RST_N = 1'b0;
   logic             SUPPLY_OK = 1'b0;
   logic             req_valid;
   logic             req_write;
   cdb_addr_t        req_addr;
   cdb_byte_t        req_wdata;
   logic             req_ack;
   cdb_byte_t        rdata;
   logic             dl_busy;
   logic             se_fetch;
   logic [CB*8-1:0]  active_cfg;
   int               fail_count = 0;
   int               num_checks = 0;

   always #25 MCLK = ~MCLK;

   cdb_top #(.CFG_BYTES(CB), .NVM_BYTES(64), .SE_DELAY_CYC(SD)) uut
   (
      .MCLK(MCLK), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
      .REQ_ACK(req_ack), .RDATA(rdata), .DL_BUSY(dl_busy), .SE_FETCH(se_fetch),
      .ACTIVE_CFG(active_cfg)
   );

   cdb_host_model host
   (
      .mclk(MCLK), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ack(req_ack), .rdata(rdata)
   );

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hw(input cdb_addr_t a, input cdb_byte_t d);
      cdb_byte_t rd;
      logic      ok;
      host.xfer(1'b1, a, d, 200, rd, ok);
      chk(ok, 1'b1);
   endtask

   task automatic hr(input cdb_addr_t a, input cdb_byte_t exp);
      cdb_byte_t rd;
      logic      ok;
      host.xfer(1'b0, a, 8'h00, 200, rd, ok);
      chk({ok, rd}, {1'b1, exp});
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_power_up;
      cdb_byte_t rd;
      logic      ok;
      int        n;
      repeat (10) @(posedge MCLK);
      #2;
      chk({dl_busy, active_cfg}, {1'b1, 64'h0});
      host.xfer(1'b0, 16'h0090, 8'h00, 5, rd, ok);
      chk(ok, 1'b0);
      SUPPLY_OK = 1'b1;
      n = 0;
      while (dl_busy !== 1'b0 && n < 100)
      begin
         chk(active_cfg, 64'h0);
         @(posedge MCLK);
         #2;
         n++;
      end
      chk(n >= CB + 1 && n <= CB + 3, 1'b1);
      chk(active_cfg, {CB{8'hff}});
      n = 0;
      while (se_fetch !== 1'b1 && n < 100)
      begin
         @(posedge MCLK);
         #2;
         n++;
      end
      chk(n, SD);
      @(posedge MCLK);
      #2;
      chk(se_fetch, 1'b0);
      hr(16'h0090, 8'h00);
      hr(16'h00a0, 8'h00);
      $display("test power_up done");
   endtask

   task automatic test_transparent;
      hw(16'h0090, 8'h01);
      hw(16'h0003, 8'ha5);
      chk(active_cfg[8*3 +: 8], 8'ha5);
      $display("test transparent done");
   endtask

   task automatic test_staged;
      hw(16'h0090, 8'h00);
      hw(16'h0002, 8'h3c);
      repeat (2) @(posedge MCLK);
      #2;
      chk(active_cfg[8*2 +: 8], 8'hff);
      hr(16'h0002, 8'h3c);
      hw(16'h0090, 8'h02);
      repeat (2) @(posedge MCLK);
      #2;
      chk(active_cfg[8*2 +: 8], 8'h3c);
      chk(active_cfg[8*3 +: 8], 8'ha5);
      hr(16'h0090, 8'h00);
      $display("test staged done");
   endtask

   task automatic test_store;
      hw(16'h0090, 8'h01);
      hw(16'hf801, 8'h12);
      hr(16'hf801, 8'h12);
      chk(active_cfg[8*1 +: 8], 8'hff);
      hw(16'h0091, 8'h00);
      hr(16'hf801, 8'h12);
      hw(16'h00d8, 8'h01);
      hr(16'h0003, 8'hff);
      chk(active_cfg[8*1 +: 8], 8'h12);
      chk(active_cfg[8*3 +: 8], 8'hff);
      hw(16'h0090, 8'h05);
      hw(16'h0091, 8'h00);
      hr(16'hf801, 8'hff);
      hw(16'h0090, 8'h00);
      hw(16'hf802, 8'h77);
      hr(16'hf802, 8'hff);
      hw(16'h0090, 8'h02);
      hr(16'hf802, 8'h77);
      $display("test store done");
   endtask

   initial
   begin
      repeat (6) @(posedge MCLK);
      #2;
      RST_N = 1'b1;
      test_power_up();
      test_transparent();
      test_staged();
      test_store();
      final_report();
   end

   // A hang in any handshake ends the run long after the expected hundred or so cycles.
   initial
   begin
      #(50 * 20000);
      fail_count++;
      final_report();
   end
endmodule // config_download_double_buffer_tb
